// ==== common/msp_defines.svh ====
// constants for the motor serial setup port: timing, offsets, fields, reset values
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define MSP_CLK_PERIOD_NS  8
`define MSP_FRAME_BITS     16
`define MSP_T_SS_MIN_NS    1500
`define MSP_T_SS_MAX_NS    4000
`define MSP_SS_MASK_CYC    ((`MSP_T_SS_MIN_NS + `MSP_CLK_PERIOD_NS - 1) / `MSP_CLK_PERIOD_NS)
`define MSP_T_COD_MIN_NS   100
`define MSP_T_COD_MAX_NS   1000
`define MSP_COD_CYC        ((`MSP_T_COD_MIN_NS + `MSP_CLK_PERIOD_NS - 1) / `MSP_CLK_PERIOD_NS)
`define MSP_T_ODL_MAX_NS   4000
`define MSP_ODL_CYC        (`MSP_T_ODL_MAX_NS / `MSP_CLK_PERIOD_NS)
`define MSP_RST_PULSE_NS   40000000
`define MSP_RST_PULSE_CYC  ((`MSP_RST_PULSE_NS + `MSP_CLK_PERIOD_NS - 1) / `MSP_CLK_PERIOD_NS)

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MSP_OFS_WORD_ONE   8'h00
`define MSP_OFS_WORD_TWO   8'h04
`define MSP_OFS_SETUP      8'h08
`define MSP_OFS_EXT        8'h0c
`define MSP_OFS_STATUS     8'h10
`define MSP_OFS_CTRL       8'h14

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define MSP_EXT_IGNORE_BIT 4
`define MSP_EXT_NORST_BIT  5
`define MSP_SEL_DEVID_BASE 4'h8
`define MSP_SEL_VENDOR     4'hb
`define MSP_SEL_ZERO       4'hc
`define MSP_SEL_ONE        4'hf
`define MSP_WORD_RST       16'h0000
`define MSP_CTRL_RST       1'b1

`endif

// ==== common/msp_pkg.sv ====
// types shared by the motor serial setup port
package msp_pkg;
  // where a latched frame of port one goes
  typedef enum logic [1:0]
  {
    MSP_TGT_WORK  = 2'b00,
    MSP_TGT_SETUP = 2'b01,
    MSP_TGT_EXT   = 2'b10
  } msp_target_e;
endpackage

// ==== rtl/msp_top.sv ====
// motor serial setup port: two serial ports, setup registers, logic out, dead time, apb
// How it works
// - each falling serial clock shifts data into the lsb; frames are sixteen bits.
// - the rising strobe after sixteen bits copies the whole word at once.
// - strobe level is ignored during shifting; only its rising edge acts.
// - two fully independent ports, one for bridges a-b, one for c-d.
// - power-down low shuts every bridge output off (high impedance).
// - power-down low clears all stored stepper parameters to zero.
// - sleeping strobe with data low loads the setup register.
// - sleeping strobe with data high loads the extended setup register.
// - extended setup routes one protection signal to the logic output.
// - extended bits can ignore protection and suppress the reset pulse.
// - three-bit device id and one-bit vendor id are readable bit by bit.
// - a four-bit selector in extended setup picks the logic output source.
// - selector 1100 gives constant zero, 1111 constant one, within 4000 ns.
// - strobes are masked for 1.5 to 4 us after a power-down change.
// - each bridge leg waits 100 to 1000 ns between opposite transistors.
// - setup register changes only on a sleeping strobe with data low.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "msp_defines.svh"

// ----------------------------------------
// serial port: pin sync, shifter, strobe edge
// ----------------------------------------
module msp_serial_port #(
  parameter int W = `MSP_FRAME_BITS
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  input  wire logic         i_ce,
  input  wire logic         i_sclk,
  input  wire logic         i_sdata,
  input  wire logic         i_strobe,
  output logic              o_latch,
  output logic [W-1:0]      o_word,
  output logic              o_data_level
);
  logic [2:0] s1;
  logic [2:0] s2;
  logic       clk_prev;
  logic       stb_prev;
  wire        clk_fall = clk_prev & ~s2[0];
  wire        stb_rise = ~stb_prev & s2[2];

  // two flops on every pin; only s2 is looked at
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s1       <= 3'h0;
      s2       <= 3'h0;
      clk_prev <= 1'b0;
      stb_prev <= 1'b0;
    end
    else if (i_ce)
    begin
      s1       <= {i_strobe, i_sdata, i_sclk};
      s2       <= s1;
      clk_prev <= s2[0];
      stb_prev <= s2[2];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_word <= W'(0);
    else if (i_ce && clk_fall)
      o_word <= {o_word[W-2:0], s2[1]};
  end

  // strobe level alone never touches the shifter, only its edge latches
  assign o_latch      = i_ce & stb_rise;
  assign o_data_level = s2[1];

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  chk_shift_lsb_in: assert property ((i_ce && clk_fall) |=>
    (o_word[0] == $past(s2[1]) && o_word[W-1:1] == $past(o_word[W-2:0])))
    else $error("serial bit not shifted into lsb");
  chk_strobe_no_shift: assert property ((!clk_fall) |=> $stable(o_word))
    else $error("shifter moved without a clock fall");
endmodule

// ----------------------------------------
// one bridge leg with crossover delay
// ----------------------------------------
module msp_deadtime #(
  parameter int DT_CYC = `MSP_COD_CYC
) (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  input  wire logic i_en,
  input  wire logic i_cmd,
  output logic      o_hi,
  output logic      o_lo
);
  localparam logic [7:0] DT = 8'(DT_CYC);
  logic       cur;
  logic [7:0] dcnt;
  wire        change = ~i_en | (i_cmd != cur);

  // both off for DT+1 cycles on every change, then the new side on
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_hi <= 1'b0;
      o_lo <= 1'b0;
      cur  <= 1'b0;
      dcnt <= DT;
    end
    else if (i_ce)
    begin
      if (change)
      begin
        o_hi <= 1'b0;
        o_lo <= 1'b0;
        cur  <= i_cmd;
        dcnt <= DT;
      end
      else if (dcnt != 8'h00)
        dcnt <= dcnt - 8'h01;
      else
      begin
        o_hi <= cur;
        o_lo <= ~cur;
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  chk_leg_never_both: assert property (!(o_hi && o_lo))
    else $error("both transistors of a leg on");
  chk_leg_gap_hi: assert property ($fell(o_hi) |-> !o_lo ##1 !o_lo [*8])
    else $error("low side on too soon after high side off");
endmodule

// ----------------------------------------
// top: two ports, setup state, logic out, apb
// ----------------------------------------
module msp_top #(
  parameter int        NPROT         = 8,
  parameter int        SS_MASK_CYC   = `MSP_SS_MASK_CYC,
  parameter int        RST_PULSE_CYC = `MSP_RST_PULSE_CYC,
  parameter logic [2:0] DEVICE_ID    = 3'h5, // value is arbitrary
  parameter logic      VENDOR_ID     = 1'b1  // value is arbitrary
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  input  wire logic             i_serial_clock_port_one,
  input  wire logic             i_serial_data_port_one,
  input  wire logic             i_latch_pulse_port_one,
  input  wire logic             i_serial_clock_port_two,
  input  wire logic             i_serial_data_port_two,
  input  wire logic             i_latch_pulse_port_two,
  input  wire logic             i_power_down_n,
  input  wire logic             i_supply_low,
  input  wire logic [NPROT-1:0] i_prot,
  input  wire logic [7:0]       i_leg_cmd,
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  input  wire logic [3:0]       i_pstrb,
  output logic [31:0]           o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  output logic                  o_logic_out,
  output logic                  o_reset_output_n,
  output logic [7:0]            o_gate_hi,
  output logic [7:0]            o_gate_lo,
  output logic [15:0]           o_setup,
  output logic [15:0]           o_ext_setup,
  output logic [15:0]           o_word_one,
  output logic [15:0]           o_word_two
);
  localparam int         PW   = $clog2(RST_PULSE_CYC + 1);
  localparam logic [7:0] MASK = 8'(SS_MASK_CYC);
  localparam logic [PW-1:0] PULSE = PW'(RST_PULSE_CYC);

  logic             lat1;
  logic             lat2;
  logic             dl1;
  logic [15:0]      sh1;
  logic [15:0]      sh2;
  logic [1:0]       pd_s1;
  logic [1:0]       pd_s2;
  logic             pd_prev;
  logic [NPROT-1:0] prot_s1;
  logic [NPROT-1:0] prot_s2;
  logic             prot_prev;
  logic [7:0]       mask;
  logic [PW-1:0]    pulse;
  logic             ctrl_en;

  msp_serial_port #(.W(`MSP_FRAME_BITS)) u_port_one (
    .i_mclk       (i_mclk),
    .i_rstn       (i_rstn),
    .i_ce         (i_ce),
    .i_sclk       (i_serial_clock_port_one),
    .i_sdata      (i_serial_data_port_one),
    .i_strobe     (i_latch_pulse_port_one),
    .o_latch      (lat1),
    .o_word       (sh1),
    .o_data_level (dl1)
  );
  msp_serial_port #(.W(`MSP_FRAME_BITS)) u_port_two (
    .i_mclk       (i_mclk),
    .i_rstn       (i_rstn),
    .i_ce         (i_ce),
    .i_sclk       (i_serial_clock_port_two),
    .i_sdata      (i_serial_data_port_two),
    .i_strobe     (i_latch_pulse_port_two),
    .o_latch      (lat2),
    .o_word       (sh2),
    .o_data_level ()
  );

  // pin synchronisers for power-down, supply monitor and protection flags
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pd_s1   <= 2'h0;
      pd_s2   <= 2'h0;
      prot_s1 <= '0;
      prot_s2 <= '0;
    end
    else if (i_ce)
    begin
      pd_s1   <= {i_supply_low, i_power_down_n};
      pd_s2   <= pd_s1;
      prot_s1 <= i_prot;
      prot_s2 <= prot_s1;
    end
  end

  // derived state; pd_prev resets low so a device born awake also masks once
  wire asleep    = ~pd_s2[0];
  wire sup_low   = pd_s2[1];
  wire pd_change = pd_prev != pd_s2[0];
  wire mask_on   = mask != 8'h00;
  wire ok1       = lat1 & ~mask_on;
  wire ok2       = lat2 & ~mask_on;
  wire prot_any  = |prot_s2;
  wire prot_rise = prot_any & ~prot_prev;
  wire react     = prot_any & ~o_ext_setup[`MSP_EXT_IGNORE_BIT];
  wire drive_ok  = ~asleep & ~react & o_reset_output_n & ctrl_en;
  msp_pkg::msp_target_e tgt1;
  assign tgt1 = ~asleep ? msp_pkg::MSP_TGT_WORK :
                (dl1 ? msp_pkg::MSP_TGT_EXT : msp_pkg::MSP_TGT_SETUP);

  // strobe mask after each power-down edge, held to the short end of the window
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pd_prev <= 1'b0;
      mask    <= 8'h00;
    end
    else if (i_ce)
    begin
      pd_prev <= pd_s2[0];
      mask    <= pd_change ? MASK : (mask_on ? mask - 8'h01 : 8'h00);
    end
  end

  // sleeping strobes pick setup or extended setup by data level
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_setup     <= `MSP_WORD_RST;
      o_ext_setup <= `MSP_WORD_RST;
    end
    else if (ok1 && tgt1 == msp_pkg::MSP_TGT_SETUP)
      o_setup <= sh1;
    else if (ok1 && tgt1 == msp_pkg::MSP_TGT_EXT)
      o_ext_setup <= sh1;
  end

  // awake strobe copies the word; sleep clears the parameters
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_word_one <= `MSP_WORD_RST;
      o_word_two <= `MSP_WORD_RST;
    end
    else if (i_ce)
    begin
      if (asleep)
        o_word_one <= `MSP_WORD_RST;
      else if (ok1)
        o_word_one <= sh1;
      if (asleep)
        o_word_two <= `MSP_WORD_RST;
      else if (ok2)
        o_word_two <= sh2;
    end
  end

  wire [3:0] sel    = o_ext_setup[3:0];
  wire       is_id  = sel >= `MSP_SEL_DEVID_BASE && sel < `MSP_SEL_VENDOR;
  wire       id_bit = DEVICE_ID[sel[1:0]];
  wire       next_logic_out = ~sel[3]               ? prot_s2[sel[2:0]] :
                              is_id                 ? id_bit :
                              sel == `MSP_SEL_VENDOR ? VENDOR_ID :
                              sel == `MSP_SEL_ONE    ? 1'b1 : 1'b0;

  // reset pulse on a new protection event unless suppressed
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_logic_out      <= 1'b0;
      prot_prev        <= 1'b0;
      pulse            <= PW'(0);
      o_reset_output_n <= 1'b0;
    end
    else if (i_ce)
    begin
      o_logic_out      <= next_logic_out;
      prot_prev        <= prot_any;
      pulse            <= (prot_rise && !o_ext_setup[`MSP_EXT_NORST_BIT]) ? PULSE :
                          (pulse != PW'(0) ? pulse - PW'(1) : PW'(0));
      o_reset_output_n <= ~sup_low && pulse == PW'(0);
    end
  end

  // eight legs, all off while asleep or on an honoured fault
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_leg
      msp_deadtime #(.DT_CYC(`MSP_COD_CYC)) u_leg (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .i_ce   (i_ce),
        .i_en   (drive_ok),
        .i_cmd  (i_leg_cmd[g]),
        .o_hi   (o_gate_hi[g]),
        .o_lo   (o_gate_lo[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // apb slave, zero wait; read data captured in setup cycle
  // ----------------------------------------
  wire setup_ph = i_psel & ~i_penable;
  wire access   = i_psel & i_penable & i_ce;
  wire hit_w1   = i_paddr == `MSP_OFS_WORD_ONE;
  wire hit_w2   = i_paddr == `MSP_OFS_WORD_TWO;
  wire hit_su   = i_paddr == `MSP_OFS_SETUP;
  wire hit_ex   = i_paddr == `MSP_OFS_EXT;
  wire hit_st   = i_paddr == `MSP_OFS_STATUS;
  wire hit_ct   = i_paddr == `MSP_OFS_CTRL;
  wire hit_any  = hit_w1 | hit_w2 | hit_su | hit_ex | hit_st | hit_ct;
  wire [31:0] status = {28'h0, o_logic_out, o_reset_output_n, mask_on, asleep};
  wire [31:0] next_prdata = hit_w1 ? {16'h0, o_word_one} :
                            hit_w2 ? {16'h0, o_word_two} :
                            hit_su ? {16'h0, o_setup} :
                            hit_ex ? {16'h0, o_ext_setup} :
                            hit_st ? status :
                            hit_ct ? {31'h0, ctrl_en} : 32'h0;
  assign o_pready  = i_ce;
  assign o_pslverr = access & ~hit_any;

  // drive enable is the only writable bit; everything else is read-only state
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_prdata <= 32'h0;
      ctrl_en  <= `MSP_CTRL_RST;
    end
    else if (i_ce)
    begin
      if (setup_ph && !i_pwrite)
        o_prdata <= next_prdata;
      if (access && i_pwrite && hit_ct && i_pstrb[0])
        ctrl_en <= i_pwdata[0];
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  chk_word_latch_awake: assert property ((ok1 && !asleep) |=> o_word_one == $past(sh1))
    else $error("awake strobe did not copy port one word");
  chk_word_two_latch: assert property ((ok2 && !asleep) |=> o_word_two == $past(sh2))
    else $error("port two word not latched");
  chk_sleep_clears: assert property ((i_ce && asleep) |=> (o_word_one == 16'h0 && o_word_two == 16'h0))
    else $error("parameters not cleared in sleep");
  chk_sleep_outputs_off: assert property ((i_ce && asleep) |=> (o_gate_hi == 8'h0 && o_gate_lo == 8'h0))
    else $error("bridge driven while asleep");
  chk_setup_target: assert property ((ok1 && asleep && !dl1) |=> o_setup == $past(sh1))
    else $error("setup register not loaded");
  chk_ext_target: assert property ((ok1 && asleep && dl1) |=> o_ext_setup == $past(sh1))
    else $error("extended setup register not loaded");
  chk_setup_guarded: assert property (!(ok1 && asleep && !dl1) |=> $stable(o_setup))
    else $error("setup register changed outside setup mode");
  chk_mask_load: assert property ((i_ce && pd_change) |=> mask == MASK)
    else $error("strobe mask not started");
  chk_mask_blocks: assert property ((lat1 && mask_on) |=> ($stable(o_setup) && $stable(o_ext_setup)))
    else $error("masked strobe took effect");
  chk_const_zero: assert property ((i_ce && sel == `MSP_SEL_ZERO) |=> !o_logic_out)
    else $error("logic out not zero for 1100");
  chk_const_one: assert property ((i_ce && sel == `MSP_SEL_ONE) |=> o_logic_out)
    else $error("logic out not one for 1111");
  chk_prot_route: assert property ((i_ce && !sel[3]) |=> o_logic_out == $past(prot_s2[sel[2:0]]))
    else $error("protection signal not routed");
  chk_devid_bit: assert property ((i_ce && sel == `MSP_SEL_DEVID_BASE) |=> o_logic_out == DEVICE_ID[0])
    else $error("device id bit wrong");
  chk_rst_suppress: assert property ((i_ce && prot_rise && o_ext_setup[`MSP_EXT_NORST_BIT] && pulse == PW'(0)) |=> pulse == PW'(0))
    else $error("reset pulse not suppressed");

  cov_awake_frame: cover property (ok1 && !asleep);
  cov_setup_frame: cover property (ok1 && tgt1 == msp_pkg::MSP_TGT_SETUP);
  cov_ext_frame:   cover property (ok1 && tgt1 == msp_pkg::MSP_TGT_EXT);
  cov_rst_pulse:   cover property (prot_rise && !o_ext_setup[`MSP_EXT_NORST_BIT]);
endmodule

// ==== tb/msp_host_model.sv ====
// host-side model that drives one three-wire serial port of the setup block
`timescale 1ns/1ns

module msp_host_model #(
  parameter int HALF = 5 // mclk cycles per half link period, 80 ns link clock
) (
  input  wire logic i_mclk,
  output logic      o_sclk,
  output logic      o_sdata,
  output logic      o_strobe
);
  // link clock stands low between frames, strobe idles low
  initial
  begin
    o_sclk   = 1'b0;
    o_sdata  = 1'b0;
    o_strobe = 1'b0;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge i_mclk);
  endtask

  // sixteen bits with the strobe held at stb_lvl, strobe pulse only after them
  // data level at the strobe rise picks the target while asleep
  task automatic send(input logic [15:0] word, input logic sel, input logic stb_lvl);
    o_strobe <= stb_lvl;
    for (int i = 15; i >= 0; i--)
    begin
      o_sdata <= word[i];
      o_sclk  <= 1'b1;
      wait_half();
      o_sclk <= 1'b0;
      wait_half();
    end
    o_sdata  <= sel;
    o_strobe <= 1'b0;
    wait_half();
    o_strobe <= 1'b1;
    wait_half();
    o_strobe <= 1'b0;
    // a released data line must not keep looking valid
    o_sdata <= ~sel;
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the motor serial setup port
`timescale 1ns/1ns
`include "msp_defines.svh"

module tb;
  localparam int         PULSE = 50;
  localparam int         MASK  = 200;  // strobe mask plus pin sync
  localparam logic [2:0] ID    = 3'h6; // value is arbitrary
  localparam logic       VID   = 1'b0; // value is arbitrary
  logic        mclk, rstn, pd_n, psel, penable, pwrite, pready, pslverr, lout, rout_n;
  logic        sclk1, sdat1, stb1, sclk2, sdat2, stb2, er, sup;
  logic [7:0]  prot, leg, paddr, ghi, glo;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] setup, ext, w1, w2;
  logic [3:0]  sel_tab [7] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hf, 4'hd};
  logic        exp_tab [7] = '{ID[0], ID[1], ID[2], VID, 1'b0, 1'b1, 1'b0};
  int          error_cnt, checked, cyc, n;

  msp_host_model host_one (.i_mclk(mclk), .o_sclk(sclk1), .o_sdata(sdat1), .o_strobe(stb1));
  msp_host_model host_two (.i_mclk(mclk), .o_sclk(sclk2), .o_sdata(sdat2), .o_strobe(stb2));

  msp_top #(.RST_PULSE_CYC(PULSE), .DEVICE_ID(ID), .VENDOR_ID(VID)) msp_top_inst (
    .i_mclk(mclk), .i_rstn(rstn), .i_ce(1'b1),
    .i_serial_clock_port_one(sclk1), .i_serial_data_port_one(sdat1),
    .i_latch_pulse_port_one(stb1), .i_serial_clock_port_two(sclk2),
    .i_serial_data_port_two(sdat2), .i_latch_pulse_port_two(stb2),
    .i_power_down_n(pd_n), .i_supply_low(sup), .i_prot(prot), .i_leg_cmd(leg),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_logic_out(lout), .o_reset_output_n(rout_n),
    .o_gate_hi(ghi), .o_gate_lo(glo), .o_setup(setup), .o_ext_setup(ext),
    .o_word_one(w1), .o_word_two(w2));

  // ----------------------------------------
  // clock, timeout, shared tasks
  // ----------------------------------------
  always #4 mclk = ~mclk;

  // bounds a hang; the full run needs well under a quarter of this
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // no cycle count is assumed; only the bench timeout ends this wait
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    apb(1'b0, `MSP_OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    apb(1'b1, `MSP_OFS_SETUP, 32'hffff);
    apb(1'b0, `MSP_OFS_SETUP, 32'h0);
    chk("setup ro", 32'h0, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
  endtask

  task automatic t_setup;
    pd_n <= 1'b0;
    repeat (MASK) @(posedge mclk);
    host_one.send(16'ha5c3, 1'b0, 1'b1);
    repeat (7) @(posedge mclk);
    chk("setup word", 32'ha5c3, {16'h0, setup});
    chk("ext untouched", 32'h0, {16'h0, ext});
  endtask

  task automatic t_ext;
    for (int i = 0; i < 7; i++)
    begin
      host_one.send({12'h000, sel_tab[i]}, 1'b1, 1'b0);
      repeat (8) @(posedge mclk);
      chk("logic out sel", {31'h0, exp_tab[i]}, {31'h0, lout});
    end
    chk("setup kept", 32'ha5c3, {16'h0, setup});
  endtask

  task automatic t_prot;
    host_one.send(16'h0002, 1'b1, 1'b0);
    prot <= 8'h04;
    repeat (6) @(posedge mclk);
    chk("prot routed", 32'h1, {31'h0, lout});
    chk("reset pulse", 32'h0, {31'h0, rout_n});
    prot <= 8'h00;
    repeat (PULSE + 10) @(posedge mclk);
    chk("pulse over", 32'h1, {31'h0, rout_n});
    host_one.send(16'h0022, 1'b1, 1'b0);
    prot <= 8'h04;
    repeat (6) @(posedge mclk);
    chk("pulse muted", 32'h1, {31'h0, rout_n});
    chk("ext word", 32'h0022, {16'h0, ext});
    prot <= 8'h00;
    // supply dip holds the reset output low until it recovers
    sup <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("reset out supply low", 32'h0, {31'h0, rout_n});
    sup <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("reset out recovered", 32'h1, {31'h0, rout_n});
  endtask

  task automatic t_wake;
    pd_n <= 1'b1;
    host_one.send(16'h1234, 1'b0, 1'b0);
    repeat (7) @(posedge mclk);
    chk("masked strobe", 32'h0, {16'h0, w1});
    repeat (40) @(posedge mclk);
    host_one.send(16'h1234, 1'b0, 1'b0);
    host_two.send(16'hbeef, 1'b0, 1'b1);
    repeat (7) @(posedge mclk);
    chk("word one", 32'h1234, {16'h0, w1});
    chk("word two", 32'hbeef, {16'h0, w2});
    chk("setup awake", 32'ha5c3, {16'h0, setup});
    apb(1'b0, `MSP_OFS_WORD_ONE, 32'h0);
    chk("word one bus", 32'h1234, rd);
  endtask

  task automatic t_leg;
    chk("low side on", 32'h1, {31'h0, glo[0] & ~ghi[0]});
    leg <= 8'h01;
    n = 0;
    @(posedge mclk);
    while (ghi[0] !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge mclk);
    end
    // n counts one edge more than the off gap; 100 to 1000 ns is 13 to 125 cycles
    chk("dead time", 32'h1, {31'h0, n >= 14 && n <= 126});
    chk("low side off", 32'h0, {31'h0, glo[0]});
  endtask

  task automatic t_sleep;
    pd_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("gates off", 32'h0, {16'h0, ghi, glo});
    chk("words cleared", 32'h0, {w1, w2});
  endtask

  // setup over port one asleep, after reset out, then wake
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    pd_n = 1'b1;
    sup = 1'b0;
    prot = 8'h00;
    leg = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    n = 0;
    while (rout_n !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge mclk);
    end
    chk("reset out high", 32'h1, {31'h0, rout_n});
    t_regs();
    t_setup();
    t_ext();
    t_prot();
    t_wake();
    t_leg();
    t_sleep();
    end_of_test();
  end
endmodule
